// File: common/sci_map.svh
// constants of the sdram command interface: field positions, codes, reset values
`ifndef SCI_MAP_SVH
`define SCI_MAP_SVH

// =====================================================================
// mode register field positions
`define SCI_MR_BL_MSB 2
`define SCI_MR_BL_LSB 0
`define SCI_MR_BT_BIT 3
`define SCI_MR_CL_MSB 6
`define SCI_MR_CL_LSB 4
`define SCI_MR_RESET 12'h020

// =====================================================================
// mode field codes
`define SCI_BL_CODE_1 3'h0
`define SCI_BL_CODE_2 3'h1
`define SCI_BL_CODE_4 3'h2
`define SCI_BL_CODE_8 3'h3
`define SCI_BL_CODE_PAGE 3'h7
`define SCI_CL_CODE_3 3'h3

// =====================================================================
// column wrap masks per burst length
`define SCI_MASK_BL1 9'h000
`define SCI_MASK_BL2 9'h001
`define SCI_MASK_BL4 9'h003
`define SCI_MASK_BL8 9'h007
`define SCI_MASK_PAGE 9'h1ff

// =====================================================================
// address bit that selects auto precharge / precharge all
`define SCI_AP_BIT 10

// =====================================================================
// write queue geometry: bank 2 + row 12 + column 9 + data 16 + enables 2
`define SCI_WQ_WIDTH 41
`define SCI_WQ_DEPTH 16

`endif

// File: common/sci_pkg.sv
// types shared by the sdram command interface files
package sci_pkg;
	typedef logic [11:0] sci_row_t;
	typedef logic [8:0] sci_col_t;
	typedef logic [1:0] sci_bank_t;
	typedef logic [15:0] sci_word_t;
	typedef logic [1:0] sci_mask_t;
	typedef logic [11:0] sci_mode_t;
	// low-power condition entered while clock enable is low
	typedef enum logic [1:0] {
		PWR_RUN,
		PWR_DOWN,
		PWR_SUSPEND,
		PWR_SELF_REFRESH
	} sci_pwr_e;
endpackage

// File: core/sci_fifo.sv
// write queue fifo with registered output stage
`timescale 1ns/10ps
module sci_fifo
	import sci_pkg::*;
#(
	parameter int WIDTH = 41,
	parameter int DEPTH = 16
) (
	// clock, reset, freeze
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = AW + 1;

	// =================================================================
	// storage and pointers
	logic [WIDTH-1:0] mem_q [DEPTH]; // entries; pointers wrap, depth is a power of two
	logic [AW-1:0] wr_ptr_q; // next slot to fill
	logic [AW-1:0] rd_ptr_q; // next slot to drain
	logic [CW-1:0] count_q; // entries held in memory, output stage excluded
	logic out_valid_q; // output stage holds a word
	logic [WIDTH-1:0] out_data_q; // output stage word

	// =================================================================
	// handshake terms
	wire push = in_valid && in_ready;
	wire pop = (count_q != '0) && (!out_valid_q || out_ready);
	assign in_ready = count_q < CW'(DEPTH);
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;

	// memory write, no reset needed on data
	always_ff @(posedge ref_clk) begin
		if (clk_en && push) begin
			mem_q[wr_ptr_q] <= in_data;
		end
	end

	// pointers and count
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
		end else if (clk_en) begin
			wr_ptr_q <= wr_ptr_q + AW'(push);
			rd_ptr_q <= rd_ptr_q + AW'(pop);
			count_q <= count_q + CW'(push) - CW'(pop);
		end
	end

	// output stage refills whenever it empties or is taken
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			out_valid_q <= 1'b0;
			out_data_q <= '0;
		end else if (clk_en) begin
			if (pop) begin
				out_valid_q <= 1'b1;
				out_data_q <= mem_q[rd_ptr_q];
			end else if (out_ready) begin
				out_valid_q <= 1'b0;
			end
		end
	end
endmodule

// File: core/sci_sdram_cmd.sv
// sdram device side: command decode, bank state, bursts, data path
`timescale 1ns/10ps
`include "sci_map.svh"
module sci_sdram_cmd
	import sci_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// command pins, synchronous to ref_clk
	input wire logic clock_enable,
	input wire logic chip_select_n,
	input wire logic row_strobe_n,
	input wire logic column_strobe_n,
	input wire logic write_strobe_n,
	input wire logic [11:0] address_lines,
	input wire logic [1:0] bank_select_lines,
	input wire logic [1:0] byte_masks,
	// data pins split into input, output, per-byte enable
	input wire logic [15:0] data_lines_in,
	output logic [15:0] data_lines_out,
	output logic [1:0] data_lines_oe,
	// storage array read port, one cycle read latency
	output logic array_rd_en,
	output logic [1:0] array_rd_bank,
	output logic [11:0] array_rd_row,
	output logic [8:0] array_rd_col,
	input wire logic [15:0] array_rd_data,
	// storage array write port, fed from the write queue
	output logic array_wr_valid,
	input wire logic array_wr_ready,
	output logic [1:0] array_wr_bank,
	output logic [11:0] array_wr_row,
	output logic [8:0] array_wr_col,
	output logic [15:0] array_wr_data,
	output logic [1:0] array_wr_byte_en,
	// status
	output logic [3:0] bank_open,
	output logic mode_loaded,
	output sci_pwr_e power_mode,
	output logic write_ready,
	output logic write_overrun
);
	// =================================================================
	// state
	sci_mode_t mode_q; // programmed operating parameters
	logic mode_loaded_q; // a mode set has been seen
	logic [3:0] open_q; // per bank open flag
	sci_row_t row_q [4]; // per bank open row
	logic burst_q; // a burst continues past this cycle
	logic burst_wr_q; // running burst is a write
	logic auto_pre_q; // close bank when the burst ends
	sci_bank_t bank_q; // bank of the running burst
	sci_col_t col_q; // column of the next beat
	sci_col_t col_start_q; // first column, for interleaved order
	sci_col_t idx_q; // beat index of the next beat
	logic [9:0] left_q; // beats still to run
	sci_pwr_e pwr_q; // low-power condition
	logic rd_en_q; // read beat issued to the array
	sci_bank_t rd_bank_q;
	sci_row_t rd_row_q;
	sci_col_t rd_col_q;
	logic tag1_q; // array data valid this cycle
	logic hold_v_q; // extra stage for the longer latency
	sci_word_t hold_q;
	sci_mask_t dqm1_q; // masks one edge old
	sci_mask_t dqm2_q; // masks two edges old
	sci_word_t dq_out_q;
	sci_mask_t dq_oe_q;
	logic wr_ready_q;
	logic overrun_q; // a write beat found the queue full; sticky until reset

	// =================================================================
	// command decode from the strobes sampled this edge
	wire sel = ~chip_select_n;
	wire is_mrs = sel & ~row_strobe_n & ~column_strobe_n & ~write_strobe_n;
	wire is_ref = sel & ~row_strobe_n & ~column_strobe_n & write_strobe_n;
	wire is_pre = sel & ~row_strobe_n & column_strobe_n & ~write_strobe_n;
	wire is_act = sel & ~row_strobe_n & column_strobe_n & write_strobe_n;
	wire is_wr = sel & row_strobe_n & ~column_strobe_n & ~write_strobe_n;
	wire is_rd = sel & row_strobe_n & ~column_strobe_n & write_strobe_n;
	wire is_stop = sel & row_strobe_n & column_strobe_n & ~write_strobe_n;
	wire is_col = is_wr | is_rd;
	wire ap_bit = address_lines[`SCI_AP_BIT];

	// =================================================================
	// mode fields
	wire [2:0] bl_code = mode_q[`SCI_MR_BL_MSB:`SCI_MR_BL_LSB];
	wire interleave = mode_q[`SCI_MR_BT_BIT];
	wire cl3 = mode_q[`SCI_MR_CL_MSB:`SCI_MR_CL_LSB] == `SCI_CL_CODE_3;
	wire full_page = bl_code == `SCI_BL_CODE_PAGE;
	// reserved codes fall back to single-word bursts
	wire [8:0] bl_mask = (bl_code == `SCI_BL_CODE_2) ? `SCI_MASK_BL2 :
		(bl_code == `SCI_BL_CODE_4) ? `SCI_MASK_BL4 :
		(bl_code == `SCI_BL_CODE_8) ? `SCI_MASK_BL8 :
		full_page ? `SCI_MASK_PAGE : `SCI_MASK_BL1;
	wire [9:0] bl_words = {1'b0, bl_mask} + 10'h001;

	// =================================================================
	// beat of this cycle: a new column command or the running burst
	wire beat_v = is_col | (burst_q & ~is_stop);
	wire beat_wr = is_col ? is_wr : burst_wr_q;
	wire [1:0] beat_bank = is_col ? bank_select_lines : bank_q;
	wire [8:0] beat_col = is_col ? address_lines[8:0] : col_q;
	wire [11:0] beat_row = row_q[beat_bank];
	wire [8:0] base_col = is_col ? address_lines[8:0] : col_start_q;
	wire [8:0] idx_n = (is_col ? 9'h000 : idx_q) + 9'h001;
	wire [8:0] seq_n = (beat_col & ~bl_mask) | ((beat_col + 9'h001) & bl_mask);
	wire [8:0] ilv_n = base_col ^ (idx_n & bl_mask);
	wire [8:0] col_n = (interleave & ~full_page) ? ilv_n : seq_n;
	wire [9:0] left_n = (is_col ? bl_words : left_q) - 10'h001;
	wire more = full_page | (left_n != 10'h000);
	wire beat_ap = is_col ? ap_bit & ~full_page : auto_pre_q;
	wire last_ap = beat_v & ~more & beat_ap;

	// =================================================================
	// write beat into the queue; masked bytes are blocked at once
	wire wq_valid = beat_v & beat_wr & ~(&byte_masks);
	wire wq_ready;
	wire [`SCI_WQ_WIDTH-1:0] wq_in = {beat_bank, beat_row, beat_col, data_lines_in,
		~byte_masks};
	wire [`SCI_WQ_WIDTH-1:0] wq_out;

	// mode register load on mode set, address carries the parameters
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			mode_q <= `SCI_MR_RESET;
			mode_loaded_q <= 1'b0;
		end else if (clock_enable && is_mrs) begin
			mode_q <= address_lines;
			mode_loaded_q <= 1'b1;
		end
	end

	// per bank open flag and row latch
	for (genvar b = 0; b < 4; b++) begin : g_bank
		wire hit = bank_select_lines == 2'(b);
		always_ff @(posedge ref_clk) begin
			if (sys_rst) begin
				open_q[b] <= 1'b0;
				row_q[b] <= '0;
			end else if (clock_enable) begin
				if (is_act && hit) begin
					open_q[b] <= 1'b1;
					row_q[b] <= address_lines;
				end else if (is_pre && (ap_bit || hit)) begin
					open_q[b] <= 1'b0;
				end else if (last_ap && beat_bank == 2'(b)) begin
					open_q[b] <= 1'b0;
				end
			end
		end
	end

	// burst sequencer; a new column command restarts it every cycle
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			burst_q <= 1'b0;
			burst_wr_q <= 1'b0;
			auto_pre_q <= 1'b0;
			bank_q <= '0;
			col_q <= '0;
			col_start_q <= '0;
			idx_q <= '0;
			left_q <= '0;
		end else if (clock_enable) begin
			// stop ends the burst; deselect lets it run on
			burst_q <= beat_v & more;
			if (beat_v) begin
				burst_wr_q <= beat_wr;
				auto_pre_q <= beat_ap;
				bank_q <= beat_bank;
				col_q <= col_n;
				col_start_q <= base_col;
				idx_q <= idx_n;
				left_q <= left_n;
			end
		end
	end

	// low-power condition picked when clock enable drops; this register
	// alone keeps running while everything else is frozen
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pwr_q <= PWR_RUN;
		end else if (clock_enable) begin
			pwr_q <= PWR_RUN;
		end else if (pwr_q == PWR_RUN) begin
			if (is_ref) begin
				pwr_q <= PWR_SELF_REFRESH;
			end else if (burst_q || rd_en_q || tag1_q || hold_v_q) begin
				pwr_q <= PWR_SUSPEND;
			end else begin
				pwr_q <= PWR_DOWN;
			end
		end
	end

	// array read request for each read beat
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			rd_en_q <= 1'b0;
			rd_bank_q <= '0;
			rd_row_q <= '0;
			rd_col_q <= '0;
		end else if (clock_enable) begin
			rd_en_q <= beat_v & ~beat_wr;
			rd_bank_q <= beat_bank;
			rd_row_q <= beat_row;
			rd_col_q <= beat_col;
		end
	end

	// read return pipeline and mask delay
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tag1_q <= 1'b0;
			hold_v_q <= 1'b0;
			hold_q <= '0;
			dqm1_q <= '0;
			dqm2_q <= '0;
		end else if (clock_enable) begin
			tag1_q <= rd_en_q;
			hold_v_q <= tag1_q;
			hold_q <= array_rd_data;
			dqm1_q <= byte_masks;
			dqm2_q <= dqm1_q;
		end
	end

	// data pin drive; latency picks the array word or the held word
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			dq_out_q <= '0;
			dq_oe_q <= '0;
		end else if (clock_enable) begin
			dq_out_q <= cl3 ? hold_q : array_rd_data;
			dq_oe_q <= {2{cl3 ? hold_v_q : tag1_q}} & ~dqm2_q;
		end
	end

	// queue status; a full queue cannot stall the pins, so the loss is flagged
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			wr_ready_q <= 1'b0;
			overrun_q <= 1'b0;
		end else if (clock_enable) begin
			wr_ready_q <= wq_ready;
			overrun_q <= overrun_q | (wq_valid & ~wq_ready);
		end
	end

	// write queue between the pins and the storage array
	sci_fifo #(
		.WIDTH(`SCI_WQ_WIDTH),
		.DEPTH(`SCI_WQ_DEPTH)
	) u_wq (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.clk_en(clock_enable),
		.in_valid(wq_valid),
		.in_ready(wq_ready),
		.in_data(wq_in),
		.out_valid(array_wr_valid),
		.out_ready(array_wr_ready),
		.out_data(wq_out)
	);

	// =================================================================
	// outputs
	assign {array_wr_bank, array_wr_row, array_wr_col, array_wr_data, array_wr_byte_en} = wq_out;
	assign data_lines_out = dq_out_q;
	assign data_lines_oe = dq_oe_q;
	assign array_rd_en = rd_en_q;
	assign array_rd_bank = rd_bank_q;
	assign array_rd_row = rd_row_q;
	assign array_rd_col = rd_col_q;
	assign bank_open = open_q;
	assign mode_loaded = mode_loaded_q;
	assign power_mode = pwr_q;
	assign write_ready = wr_ready_q;
	assign write_overrun = overrun_q;
endmodule

// File: tb/sci_array_model.sv
// storage array model: one cycle read latency, write port that can stall
`timescale 1ns/10ps
module sci_array_model (
	// clock and stall request from the bench
	input wire logic ref_clk,
	input wire logic stall,
	// read port
	input wire logic array_rd_en,
	input wire logic [1:0] array_rd_bank,
	input wire logic [11:0] array_rd_row,
	input wire logic [8:0] array_rd_col,
	output logic [15:0] array_rd_data,
	// write port
	input wire logic array_wr_valid,
	output logic array_wr_ready,
	input wire logic [1:0] array_wr_bank, array_wr_byte_en,
	input wire logic [11:0] array_wr_row,
	input wire logic [8:0] array_wr_col,
	input wire logic [15:0] array_wr_data
);
	logic [15:0] mem [logic [22:0]];
	wire [22:0] rd_key = {array_rd_bank, array_rd_row, array_rd_col};
	wire [22:0] wr_key = {array_wr_bank, array_wr_row, array_wr_col};
	assign array_wr_ready = !stall;
	initial array_rd_data = 16'h5a5a;
	// read before write at one edge; idle data toggles so stale words never match
	always @(posedge ref_clk) begin
		logic [15:0] w;
		array_rd_data <= array_rd_en ? (mem.exists(rd_key) ? mem[rd_key] : 16'h0000) :
			~array_rd_data;
		if (array_wr_valid && array_wr_ready) begin
			w = mem.exists(wr_key) ? mem[wr_key] : 16'h0000;
			if (array_wr_byte_en[0]) w[7:0] = array_wr_data[7:0];
			if (array_wr_byte_en[1]) w[15:8] = array_wr_data[15:8];
			mem[wr_key] = w;
		end
	end
endmodule

// File: tb/sci_sdram_cmd_assertions.sv
// concurrent checks on the sdram command interface pins
`timescale 1ns/10ps
module sci_sdram_cmd_assertions
	import sci_pkg::*;
(
	// clock, reset and command pins
	input wire logic ref_clk, sys_rst, clock_enable, chip_select_n,
	input wire logic row_strobe_n, column_strobe_n, write_strobe_n,
	input wire logic [11:0] address_lines,
	input wire logic [1:0] bank_select_lines, byte_masks, data_lines_oe, array_rd_bank,
	// array request and status
	input wire logic array_rd_en, mode_loaded,
	input wire logic [8:0] array_rd_col,
	input wire logic [3:0] bank_open,
	input var sci_pwr_e power_mode
);
	// ==========================================================
	// command decode as the pins present it
	wire live = clock_enable && !chip_select_n;
	wire [2:0] op = {row_strobe_n, column_strobe_n, write_strobe_n};
	wire [8:0] col_in = address_lines[8:0];
	wire is_rd = live && op == 3'h5;
	wire is_act = live && op == 3'h3;
	wire is_mrs = live && op == 3'h0;
	wire is_pre_all = live && op == 3'h2 && address_lines[10];
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================================
	// properties
	a_read_col: assert property (is_rd |=> array_rd_en && array_rd_col == $past(col_in))
		else $error("read column not taken from the low nine lines");
	a_read_bank: assert property (is_rd |=> array_rd_bank == $past(bank_select_lines))
		else $error("read bank differs from bank select");
	a_act_opens: assert property (is_act |=> bank_open[$past(bank_select_lines)])
		else $error("activate did not open the selected bank");
	a_deselect_quiet: assert property (clock_enable && chip_select_n && bank_open == 4'h0
		|=> bank_open == 4'h0) else $error("deselected pins opened a bank");
	a_pre_all: assert property (is_pre_all |=> bank_open == 4'h0)
		else $error("precharge all left a bank open");
	a_mode_set: assert property (is_mrs |=> mode_loaded)
		else $error("mode set not recorded");
	// mask moves through two stages, then loads the drive register: three enabled edges
	a_rd_mask_z: assert property (byte_masks[1] && clock_enable ##1 clock_enable
		##1 clock_enable |=> !data_lines_oe[1]) else $error("masked upper byte still driven");
	a_freeze_banks: assert property (!clock_enable |=> $stable(bank_open))
		else $error("bank state moved while clock enable low");
	a_low_power: assert property (!clock_enable && power_mode == PWR_RUN
		|=> power_mode != PWR_RUN) else $error("no low power mode entered");
	a_wake_run: assert property (clock_enable |=> power_mode == PWR_RUN)
		else $error("not running after clock enable high");
	// main scenarios reached
	c_read: cover property (is_rd);
	c_act: cover property (is_act);
	c_mode: cover property (is_mrs);
	c_self_ref: cover property (power_mode == PWR_SELF_REFRESH);
endmodule
bind sci_sdram_cmd sci_sdram_cmd_assertions u_checker (.*);

// File: tb/sci_sdram_cmd_test.sv
// self-checking bench for the sdram command interface
`timescale 1ns/10ps
module sci_sdram_cmd_test;
	import sci_pkg::*;
	logic ref_clk = 1'b0, sys_rst = 1'b1, clock_enable = 1'b1, stall = 1'b1;
	logic chip_select_n = 1'b1, row_strobe_n = 1'b1, column_strobe_n = 1'b1;
	logic write_strobe_n = 1'b1;
	logic [11:0] address_lines = 12'h000;
	logic [1:0] bank_select_lines = 2'h0, byte_masks = 2'h3;
	logic [15:0] data_lines_in = 16'h0000;
	wire [15:0] data_lines_out, array_rd_data, array_wr_data;
	wire [1:0] data_lines_oe, array_rd_bank, array_wr_bank, array_wr_byte_en;
	wire [11:0] array_rd_row, array_wr_row;
	wire [8:0] array_rd_col, array_wr_col;
	wire [3:0] bank_open;
	wire array_rd_en, array_wr_valid, array_wr_ready, mode_loaded, write_ready, write_overrun;
	sci_pwr_e power_mode;
	int miscompares = 0, checks_done = 0, cycles = 0;
	// {cs, ras, cas, we} patterns; DACT, DPRE and DRD are deselected
	localparam logic [3:0] MRS = 4'h0, REF = 4'h1, PRE = 4'h2, ACT = 4'h3, WR = 4'h4;
	localparam logic [3:0] RD = 4'h5, NO_OPERATION = 4'h7, DPRE = 4'ha, DACT = 4'hb, DRD = 4'hd;
	logic [15:0] wdat [4] = '{16'h1357, 16'h2468, 16'h9ace, 16'hbdf0};
	logic [15:0] rexp [4] = '{16'h1357, 16'h2400, 16'h9ace, 16'hbdf0};
	logic [1:0] roe [4] = '{2'h3, 2'h1, 2'h3, 2'h3};
	logic [3:0] lp_cmd [2] = '{NO_OPERATION, REF};
	sci_pwr_e lp_mode [2] = '{PWR_DOWN, PWR_SELF_REFRESH};
	always #5 ref_clk = ~ref_clk;
	sci_sdram_cmd dut (.*);
	sci_array_model u_array (.*);
	// ==========================================================
	// pin driver: one command per cycle, set at the falling edge
	task automatic cmd(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
		input logic [1:0] m = 2'h0, input logic [15:0] d = 16'h0000);
		@(negedge ref_clk);
		{chip_select_n, row_strobe_n, column_strobe_n, write_strobe_n} = c;
		bank_select_lines = b;
		address_lines = a;
		byte_masks = m;
		data_lines_in = d;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("checks_done %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// hang guard: power-up pause plus two thousand cycles, far more than the tests need
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 22000) begin
			miscompares++;
			finish_test();
		end
	end
	// ==========================================================
	// test sequence
	initial begin
		logic [15:0] keep;
		repeat (8) @(negedge ref_clk);
		sys_rst = 1'b0;
		chk("reset", 16'h0000, {5'h00, bank_open, mode_loaded, power_mode, data_lines_oe,
			write_overrun, write_ready});
		repeat (20000) @(negedge ref_clk);
		cmd(PRE, 2'h0, 12'h400);
		for (int i = 0; i < 8; i++) cmd(REF, 2'h0, 12'h000);
		cmd(MRS, 2'h0, 12'h022);
		cmd(NO_OPERATION, 2'h0, 12'h000);
		chk("mode loaded", 16'h0001, {15'h0000, mode_loaded});
		$display("init done");
		cmd(DACT, 2'h0, 12'h000);
		cmd(ACT, 2'h1, 12'hfff);
		cmd(ACT, 2'h2, 12'h0ab);
		cmd(DPRE, 2'h0, 12'h400);
		cmd(NO_OPERATION, 2'h0, 12'h000);
		chk("banks open", 16'h0006, {12'h000, bank_open});
		$display("activate done");
		// write burst with the lower byte masked on the second beat, array stalled
		for (int i = 0; i < 4; i++) cmd(i == 0 ? WR : NO_OPERATION, 2'h1, 12'h004,
			i == 1 ? 2'h1 : 2'h0, wdat[i]);
		repeat (3) cmd(NO_OPERATION, 2'h0, 12'h000);
		stall = 1'b0;
		repeat (6) cmd(NO_OPERATION, 2'h0, 12'h000);
		$display("write done");
		// read burst: column bit 11 ignored, upper mask, deselected read mid-burst
		cmd(RD, 2'h1, 12'h804);
		cmd(NO_OPERATION, 2'h0, 12'h000, 2'h2);
		cmd(DRD, 2'h1, 12'h000);
		for (int i = 0; i < 4; i++) begin
			cmd(NO_OPERATION, 2'h0, 12'h000);
			keep = {{8{roe[i][1]}}, {8{roe[i][0]}}};
			chk("read oe", {14'h0000, roe[i]}, {14'h0000, data_lines_oe});
			chk("read word", rexp[i] & keep, data_lines_out & keep);
		end
		cmd(NO_OPERATION, 2'h0, 12'h000);
		chk("oe after burst", 16'h0000, {14'h0000, data_lines_oe});
		$display("read done");
		// write every cycle into a stalled array until the queue refuses
		stall = 1'b1;
		for (int i = 0; i < 20; i++) cmd(WR, 2'h2, 12'h100 + 12'(i), 2'h0, 16'(i));
		repeat (4) cmd(NO_OPERATION, 2'h0, 12'h000);
		chk("queue full", 16'h0001, {14'h0000, write_ready, write_overrun});
		stall = 1'b0;
		repeat (40) cmd(NO_OPERATION, 2'h0, 12'h000);
		chk("queue empty", 16'h0001, {14'h0000, array_wr_valid, write_ready});
		$display("fill done");
		// power down and self refresh entry, then wake
		for (int i = 0; i < 2; i++) begin
			cmd(lp_cmd[i], 2'h0, 12'h000);
			clock_enable = 1'b0;
			cmd(ACT, 2'h0, 12'h000);
			// let the activate be sampled with clock enable still low
			cmd(NO_OPERATION, 2'h0, 12'h000);
			chk("low power", {14'h0000, lp_mode[i]}, {14'h0000, power_mode});
			chk("banks held", 16'h0006, {12'h000, bank_open});
			clock_enable = 1'b1;
			cmd(NO_OPERATION, 2'h0, 12'h000);
			chk("wake", 16'h0000, {14'h0000, power_mode});
		end
		$display("power done");
		cmd(PRE, 2'h0, 12'h400);
		cmd(NO_OPERATION, 2'h0, 12'h000);
		chk("all closed", 16'h0000, {12'h000, bank_open});
		$display("precharge done");
		// longer latency, interleaved order from column 5, auto precharge closes the bank
		cmd(MRS, 2'h0, 12'h03a);
		cmd(NO_OPERATION, 2'h0, 12'h000);
		cmd(ACT, 2'h1, 12'hfff);
		cmd(NO_OPERATION, 2'h0, 12'h000);
		cmd(RD, 2'h1, 12'h405);
		repeat (3) cmd(NO_OPERATION, 2'h0, 12'h000);
		for (int i = 0; i < 4; i++) begin
			cmd(NO_OPERATION, 2'h0, 12'h000);
			chk("cl3 oe", 16'h0003, {14'h0000, data_lines_oe});
			chk("cl3 word", rexp[i ^ 1], data_lines_out);
		end
		chk("auto precharge", 16'h0000, {12'h000, bank_open});
		$display("interleave done");
		finish_test();
	end
endmodule
